// file: pkg/conv_ctrl_regs.svh
// Register offsets, field positions, reset values and codes of the
// converter configuration block. Included by the package and the design.
`ifndef CONV_CTRL_REGS_SVH
`define CONV_CTRL_REGS_SVH
// Pointer values
`define PTR_CONV      2'h0
`define PTR_CFG       2'h1
// Configuration word reset value
`define CFG_RESET     16'h8583
// Field positions inside the configuration word
`define F_START       15
`define F_SEL_HI      14
`define F_SEL_LO      12
`define F_GAIN_HI     11
`define F_GAIN_LO     9
`define F_MODE        8
`define F_RATE_HI     7
`define F_RATE_LO     5
`define F_WINDOW      4
`define F_POL         3
`define F_LATCH       2
`define F_QUE_HI      1
`define F_QUE_LO      0
// Comparator queue codes
`define QUE_OFF       2'h3
// Largest gain code, higher codes alias onto it
`define GAIN_MAX      3'h5
// Conversion register reset value
`define CONV_RESET    16'h0000
`endif

// file: pkg/conv_ctrl_pkg.sv
// Types shared by the converter configuration block.
// Assumes conv_ctrl_regs.svh is on the include path.
`default_nettype none
package conv_ctrl_pkg;
	`include "conv_ctrl_regs.svh"
	// Word of the register file
	typedef logic [15:0] word_t;
	// Request kinds sent from the link domain to the core
	typedef enum logic [1:0] {REQ_WRITE, REQ_READCONV, REQ_ALERTRESP} req_kind_t;
	// Negative input of the multiplexer
	typedef enum logic [1:0] {NEG_IN1, NEG_IN3, NEG_GND} neg_sel_t;
endpackage
`default_nettype wire

// file: rtl/conv_ctrl.sv
// Configuration word, start/status handling and threshold comparator of a
// 16-bit converter. Assumes a serial-bus engine on linkClk that presents
// pointer/data strobes, and a converter core on mclk that reports results.
`default_nettype none
`include "conv_ctrl_regs.svh"
module conv_ctrl
	import conv_ctrl_pkg::*;
#(
	parameter int RDY_PULSE_CYC = 4	// Length of the continuous ready pulse
) (
	// Core clock and reset
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	// Link clock domain
	input  wire logic        linkClk,
	input  wire logic        linkRst,
	input  wire logic        wrStb,
	input  wire logic [1:0]  wrPtr,
	input  wire logic [15:0] wrData,
	input  wire logic        rdConvStb,
	input  wire logic        araWonStb,
	input  wire logic [1:0]  rdPtr,
	output logic      [15:0] rdData_q,
	output logic             reqReady_q,
	output logic             alertPend_q,
	// Converter core
	input  wire logic        convDone,
	input  wire logic [15:0] convResult,
	input  wire logic [15:0] highLimit,
	input  wire logic [15:0] lowLimit,
	output logic             convStart_q,
	output logic             contMode_q,
	output logic [1:0]       posSel_q,
	output neg_sel_t         negSel_q,
	output logic [2:0]       gainRangeSel_q,
	output logic [2:0]       sampleRateSel_q,
	// Alert/ready pin
	output logic             alertOut_q,
	output logic             alertOe_q
);
	localparam word_t CFG_RST = `CFG_RESET;

	// Routing of the input-select code
	function automatic logic [3:0] route(input logic [2:0] s);
		if (s[2])
			route = {s[1:0], NEG_GND};
		else if (s == 3'h0)
			route = {2'h0, NEG_IN1};
		else
			route = {s[1:0] - 2'h1, NEG_IN3};
	endfunction

	// Hits needed before the alert asserts
	function automatic logic [2:0] need(input logic [1:0] q);
		need = 3'h1 << q;
	endfunction

	// ---------------- Link domain ----------------
	req_kind_t reqKind_q;	// Kind of pending request
	word_t     reqData_q;	// Data of pending request
	logic      reqTgl_q;	// Toggles once per request
	logic      ackS1_q;	// Ack toggle, first stage
	logic      ackS2_q;	// Ack toggle, second stage
	logic      pubS1_q;	// Publish toggle, first stage
	logic      pubS2_q;	// Publish toggle, second stage
	logic      pubS3_q;	// Last seen publish toggle, also the ack
	logic      pendS1_q;	// Alert level, first stage
	word_t     linkCfg_q;	// Readback copy of the configuration
	word_t     linkConv_q;	// Readback copy of the last result
	logic      take;	// A request is accepted this cycle
	// Core-domain registers that the link side samples
	logic      reqSeen_q;	// Last handled request toggle, also the ack
	logic      pubTgl_q;	// Publish toggle
	logic      alertAct_q;	// Alert asserted, before polarity
	word_t     snapCfg_q;	// Snapshot of the configuration word
	word_t     snapConv_q;	// Snapshot of the last result

	assign take = reqReady_q && ((wrStb && wrPtr == `PTR_CFG) || rdConvStb || araWonStb);

	// Capture one request at a time; the engine must wait for reqReady_q
	always_ff @(posedge linkClk) begin
		if (linkRst) begin
			reqTgl_q   <= 1'b0;
			reqKind_q  <= REQ_WRITE;
			reqData_q  <= 16'h0000;
			reqReady_q <= 1'b0;
		end else begin
			reqReady_q <= take ? 1'b0 : (reqTgl_q == ackS2_q);
			if (take) begin
				reqTgl_q  <= ~reqTgl_q;
				reqData_q <= wrData;
				// Write outranks a data read, which outranks a response
				if (wrStb && wrPtr == `PTR_CFG)
					reqKind_q <= REQ_WRITE;
				else if (rdConvStb)
					reqKind_q <= REQ_READCONV;
				else
					reqKind_q <= REQ_ALERTRESP;
			end
		end
	end

	// Synchronisers into the link domain
	always_ff @(posedge linkClk) begin
		if (linkRst) begin
			{ackS1_q, ackS2_q}           <= 2'h0;
			{pubS1_q, pubS2_q, pubS3_q}  <= 3'h0;
			{pendS1_q, alertPend_q}      <= 2'h0;
		end else begin
			ackS1_q     <= reqSeen_q;
			ackS2_q     <= ackS1_q;
			pubS1_q     <= pubTgl_q;
			pubS2_q     <= pubS1_q;
			pubS3_q     <= pubS2_q;
			pendS1_q    <= alertAct_q;
			alertPend_q <= pendS1_q;
		end
	end

	// Copy the published snapshot; it holds still until pubS3_q is echoed
	always_ff @(posedge linkClk) begin
		if (linkRst) begin
			linkCfg_q  <= CFG_RST;
			linkConv_q <= `CONV_RESET;
			rdData_q   <= 16'h0000;
		end else begin
			if (pubS2_q != pubS3_q) begin
				linkCfg_q  <= snapCfg_q;
				linkConv_q <= snapConv_q;
			end
			// Threshold pointers are served outside this block
			case (rdPtr)
				`PTR_CONV: rdData_q <= linkConv_q;
				`PTR_CFG:  rdData_q <= linkCfg_q;
				default:   rdData_q <= 16'h0000;
			endcase
		end
	end

	// ---------------- Core domain ----------------
	logic        reqS1_q;	// Request toggle, first stage
	logic        reqS2_q;	// Request toggle, second stage
	logic        pubA1_q;	// Publish ack, first stage
	logic        pubA2_q;	// Publish ack, second stage
	logic [14:0] cfg_q;	// Writable fields
	logic        busy_q;	// Conversion in progress
	word_t       convData_q;	// Last completed result
	logic [2:0]  hitCnt_q;	// Consecutive out-of-band results
	logic [7:0]  rdyCnt_q;	// Continuous ready pulse timer
	logic        reqEvt;	// New request from the link
	logic        wrEvt;	// Configuration write
	logic        clrEvt;	// Data read or won alert response
	logic        startOk;	// Start write accepted
	logic        compEn;	// Comparator on
	logic        rdyMode;	// Limits select ready signalling
	logic        above;	// Result above the high limit
	logic        below;	// Result below the low limit
	logic        hit;	// Result counts as exceeding
	logic        setAlert;	// Enough consecutive hits
	logic        clrBand;	// Result clears a nonlatching alert
	logic        pendPub;	// Snapshot may be refreshed
	logic [3:0]  routeVal;	// Decoded input routing
	word_t       cfgWord;	// Configuration as read

	assign reqEvt  = reqS2_q != reqSeen_q;
	assign wrEvt   = reqEvt && reqKind_q == REQ_WRITE;
	assign clrEvt  = reqEvt && reqKind_q != REQ_WRITE;
	assign startOk = wrEvt && reqData_q[`F_START] && !busy_q;
	assign compEn  = cfg_q[`F_QUE_HI:`F_QUE_LO] != `QUE_OFF;
	assign rdyMode = highLimit[15] && !lowLimit[15];
	assign above   = $signed(convResult) > $signed(highLimit);
	assign below   = $signed(convResult) < $signed(lowLimit);
	assign hit     = above || (cfg_q[`F_WINDOW] && below);
	assign setAlert = convDone && hit && (hitCnt_q + 3'h1 >= need(cfg_q[1:0]));
	assign clrBand = cfg_q[`F_WINDOW] ? !hit : below;
	assign pendPub = pubTgl_q == pubA2_q;
	assign routeVal = route(cfg_q[`F_SEL_HI:`F_SEL_LO]);
	assign cfgWord = {!busy_q, cfg_q};

	// Synchronisers into the core domain
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			{reqS1_q, reqS2_q, reqSeen_q} <= 3'h0;
			{pubA1_q, pubA2_q}            <= 2'h0;
		end else begin
			reqS1_q   <= reqTgl_q;
			reqS2_q   <= reqS1_q;
			reqSeen_q <= reqS2_q;
			pubA1_q   <= pubS3_q;
			pubA2_q   <= pubA1_q;
		end
	end

	// Publish a fresh snapshot once the link has taken the last one
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			pubTgl_q   <= 1'b0;
			snapCfg_q  <= CFG_RST;
			snapConv_q <= `CONV_RESET;
		end else if (pendPub) begin
			pubTgl_q   <= ~pubTgl_q;
			snapCfg_q  <= cfgWord;
			snapConv_q <= convData_q;
		end
	end

	// Configuration fields; the start bit is not stored, it is status
	always_ff @(posedge mclk) begin
		if (sys_rst)
			cfg_q <= CFG_RST[14:0];
		else if (wrEvt)
			cfg_q <= reqData_q[14:0];
	end

	// Decoded controls towards the converter core
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			contMode_q      <= 1'b0;
			posSel_q        <= 2'h0;
			negSel_q        <= NEG_IN1;
			gainRangeSel_q  <= CFG_RST[`F_GAIN_HI:`F_GAIN_LO];
			sampleRateSel_q <= CFG_RST[`F_RATE_HI:`F_RATE_LO];
		end else begin
			contMode_q      <= !cfg_q[`F_MODE];
			posSel_q        <= routeVal[3:2];
			negSel_q        <= neg_sel_t'(routeVal[1:0]);
			// Codes above the largest range all give the smallest span
			gainRangeSel_q  <= (cfg_q[`F_GAIN_HI:`F_GAIN_LO] > `GAIN_MAX) ?
				`GAIN_MAX : cfg_q[`F_GAIN_HI:`F_GAIN_LO];
			sampleRateSel_q <= cfg_q[`F_RATE_HI:`F_RATE_LO];
		end
	end

	// Start pulse and busy flag; a start write in the done cycle of a conversion is ignored, as busy_q is still set
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			convStart_q <= 1'b0;
			busy_q      <= 1'b0;
		end else begin
			convStart_q <= startOk;
			if (startOk)
				busy_q <= 1'b1;
			else if (!cfg_q[`F_MODE])
				busy_q <= 1'b1;
			else if (convDone)
				busy_q <= 1'b0;
		end
	end

	// Result register, zero until the first conversion ends
	always_ff @(posedge mclk) begin
		if (sys_rst)
			convData_q <= `CONV_RESET;
		else if (convDone)
			convData_q <= convResult;
	end

	// Consecutive hit counter, saturating at four
	always_ff @(posedge mclk) begin
		if (sys_rst || !compEn || rdyMode)
			hitCnt_q <= 3'h0;
		else if (convDone)
			hitCnt_q <= hit ? ((hitCnt_q == 3'h4) ? 3'h4 : hitCnt_q + 3'h1) : 3'h0;
	end

	// Alert state; a new set wins over a clear in the same cycle
	always_ff @(posedge mclk) begin
		if (sys_rst || !compEn)
			alertAct_q <= 1'b0;
		else if (rdyMode)
			alertAct_q <= cfg_q[`F_MODE] ? !busy_q : (rdyCnt_q != 8'h00);
		else if (setAlert)
			alertAct_q <= 1'b1;
		else if (cfg_q[`F_LATCH] ? clrEvt : (convDone && clrBand))
			alertAct_q <= 1'b0;
	end

	// Ready pulse after each result in continuous mode
	always_ff @(posedge mclk) begin
		if (sys_rst)
			rdyCnt_q <= 8'h00;
		else if (convDone && !cfg_q[`F_MODE])
			rdyCnt_q <= 8'(RDY_PULSE_CYC);
		else if (rdyCnt_q != 8'h00)
			rdyCnt_q <= rdyCnt_q - 8'h01;
	end

	// Pin drive; floats when the comparator is off
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			alertOe_q  <= 1'b0;
			alertOut_q <= 1'b1;
		end else begin
			alertOe_q  <= compEn;
			alertOut_q <= cfg_q[`F_POL] ? alertAct_q : !alertAct_q;
		end
	end

	// ---------------- Checks ----------------
	sequence sHitDone;
		convDone && hit && compEn && !rdyMode;
	endsequence
	sequence sBackInside;
		convDone && clrBand && !hit && compEn && !rdyMode && !cfg_q[`F_LATCH];
	endsequence

	a_cfg_reset: assert property (@(posedge mclk) $past(sys_rst) && !sys_rst |-> cfgWord == CFG_RST) else $error("config not at reset value");
	a_start_once: assert property (@(posedge mclk) disable iff (sys_rst) convStart_q |-> busy_q ##1 !convStart_q) else $error("start not single");
	a_start_busy: assert property (@(posedge mclk) disable iff (sys_rst) wrEvt && busy_q |=> !convStart_q) else $error("start taken while busy");
	a_status_snap: assert property (@(posedge mclk) disable iff (sys_rst) pendPub |=> snapCfg_q[15] == !$past(busy_q)) else $error("status bit wrong");
	a_gain_clamp: assert property (@(posedge mclk) disable iff (sys_rst) cfg_q[11:9] > 3'h5 |=> gainRangeSel_q == 3'h5) else $error("gain alias wrong");
	a_off_float: assert property (@(posedge mclk) disable iff (sys_rst) !compEn |=> !alertOe_q) else $error("pin driven while off");
	a_queue_one: assert property (@(posedge mclk) disable iff (sys_rst) sHitDone and cfg_q[1:0] == 2'h0 |=> alertAct_q) else $error("alert late");
	a_queue_four: assert property (@(posedge mclk) disable iff (sys_rst) sHitDone and cfg_q[1:0] == 2'h2 and hitCnt_q < 3'h3 |=> !alertAct_q || $past(alertAct_q)) else $error("alert early");
	a_nonlatch_clr: assert property (@(posedge mclk) disable iff (sys_rst) sBackInside |=> !alertAct_q) else $error("alert stuck");
	a_latch_hold: assert property (@(posedge mclk) disable iff (sys_rst) alertAct_q && cfg_q[2] && compEn && !rdyMode && !clrEvt |=> alertAct_q || !compEn || rdyMode) else $error("latch lost");
	a_pol_level: assert property (@(posedge mclk) disable iff (sys_rst) alertOe_q && $stable(cfg_q[3]) && $stable(alertAct_q) |-> alertOut_q == (cfg_q[3] ~^ alertAct_q)) else $error("polarity wrong");
	a_result_hold: assert property (@(posedge mclk) disable iff (sys_rst) !convDone |=> $stable(convData_q)) else $error("result changed");
endmodule // conv_ctrl
`default_nettype wire

// file: verif/host_link_model.sv
// Host-side link engine model: config writes, data-read and alert-response
// events, and pointer reads, all on linkClk.
// Assumes the block's reqReady_q handshake runs on the same clock.
`default_nettype none
module host_link_model (
	// Link clock
	input  wire logic        linkClk,
	// Answers from the block
	input  wire logic        reqReady_q,
	input  wire logic [15:0] rdData_q,
	// Requests to the block
	output logic             wrStb,
	output logic [1:0]       wrPtr,
	output logic [15:0]      wrData,
	output logic             rdConvStb,
	output logic             araWonStb,
	output logic [1:0]       rdPtr
);
	timeunit 1ns;
	timeprecision 1ps;
	int errs = 0;	// Requests never taken within the bound
	// Idle values from time zero
	initial begin
		{wrStb, rdConvStb, araWonStb} = 3'h0;
		wrPtr = 2'h0;
		wrData = 16'h0000;
		rdPtr = 2'h0;
	end
	// One request, held until an edge that samples the block ready
	task automatic req(input logic [2:0] kind, input logic [1:0] p, input logic [15:0] d);
		int n;
		n = 0;
		@(posedge linkClk);
		wrStb     <= kind[0];
		rdConvStb <= kind[1];
		araWonStb <= kind[2];
		wrPtr     <= p;
		wrData    <= d;
		do begin
			@(posedge linkClk);
			n++;
		end while (reqReady_q !== 1'b1 && n < 500);
		if (n >= 500)
			errs++;
		{wrStb, rdConvStb, araWonStb} <= 3'h0;
		// Released lines must not keep showing the last value
		wrData <= ~d;
		wrPtr  <= ~p;
	endtask
	// Pointer read; the snapshot lags a few cycles of both clocks
	task automatic rd(input logic [1:0] p, output logic [15:0] v);
		@(posedge linkClk);
		rdPtr <= p;
		repeat (40) @(posedge linkClk);
		v = rdData_q;
	endtask
endmodule // host_link_model
`default_nettype wire

// file: verif/adc_config_comparator_control_tb_top.sv
// Self-checking bench for conv_ctrl with an integer model of the comparator.
// Assumes host_link_model drives the link side and the bench plays the core.
`default_nettype none
module adc_config_comparator_control_tb_top;
	import conv_ctrl_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	// Clocks and resets
	logic       mclk = 0, linkClk = 0, sys_rst = 1, linkRst = 1;
	// Link side
	logic       wrStb, rdConvStb, araWonStb, reqReady_q, alertPend_q;
	logic [1:0] wrPtr, rdPtr, posSel_q;
	// Core side
	logic       convDone, convStart_q, contMode_q, alertOut_q, alertOe_q;
	logic [2:0] gainRangeSel_q, sampleRateSel_q;
	neg_sel_t   negSel_q;
	word_t      wrData, rdData_q, convResult, highLimit, lowLimit, rv, w;
	// Bookkeeping and model state
	int         err_count = 0, checks = 0, starts = 0, pulseLen = 0;
	int         que = 3, win = 0, lat = 0, pol = 0, cnt = 0, act = 0;
	int         hi = 4096, lo = -4096;
	int         seq[9] = '{0, 1, 0, 0, 0, 0, 3, 2, 2};	// Above, mid, edge, below

	conv_ctrl #(.RDY_PULSE_CYC(4)) dut (.mclk, .sys_rst, .linkClk, .linkRst, .wrStb, .wrPtr,
		.wrData, .rdConvStb, .araWonStb, .rdPtr, .rdData_q, .reqReady_q, .alertPend_q,
		.convDone, .convResult, .highLimit, .lowLimit, .convStart_q, .contMode_q,
		.posSel_q, .negSel_q, .gainRangeSel_q, .sampleRateSel_q, .alertOut_q, .alertOe_q);
	host_link_model host (.linkClk, .reqReady_q, .rdData_q, .wrStb, .wrPtr, .wrData,
		.rdConvStb, .araWonStb, .rdPtr);

	// Core clock 20 ns; link clock 6 ns with an unrelated phase
	initial forever #10 mclk = ~mclk;
	initial begin
		#1.7;
		forever #3 linkClk = ~linkClk;
	end
	// Counts start pulses so a double launch shows up
	always @(posedge mclk) begin
		if (convStart_q === 1'b1)
			starts++;
	end
	// Single compare point
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic done(input string nm);
		$display("test %s finished", nm);
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Pin level and drive against the model
	task automatic pin;
		chk("alertOe", 16'(alertOe_q), 16'(que != 3));
		if (que != 3)
			chk("alertOut", 16'(alertOut_q), 16'(pol ? act : !act));
	endtask
	// Config write; queue off clears the alert state
	task automatic setcfg(input word_t c);
		host.req(3'h1, 2'h1, c);
		{que, lat, pol, win} = {30'h0, c[1:0], 31'h0, c[2], 31'h0, c[3], 31'h0, c[4]};
		if (que == 3)
			{act, cnt} = 64'h0;
		repeat (8) @(posedge mclk);
		pin();
	endtask
	// One finished conversion, then the model step
	task automatic conv(input word_t r, input bit cmp);
		int  need;
		bit  hit, clr;
		@(posedge mclk);
		convResult <= r;
		convDone   <= 1'b1;
		@(posedge mclk);
		convDone   <= 1'b0;
		convResult <= ~r;
		repeat (4) @(posedge mclk);
		need = (que == 2) ? 4 : que + 1;
		hit = signed'(r) > hi || (win != 0 && signed'(r) < lo);
		clr = win != 0 ? !hit : signed'(r) < lo;
		cnt = hit ? cnt + 1 : 0;
		if (hit && cnt >= need)
			act = 1;
		else if (lat == 0 && clr)
			act = 0;
		if (que == 3)
			{act, cnt} = 64'h0;
		if (cmp)
			pin();
	endtask
	// Random value of a class: above, mid, below, or exactly the high limit
	function automatic word_t val(input int k);
		case (k)
			0: return 16'(4097 + $urandom % 1000);
			1: return 16'(int'($urandom % 8193) - 4096);
			2: return 16'(-4097 - int'($urandom % 1000));
			default: return 16'h1000;
		endcase
	endfunction

	// Watchdog: the tests need well under 50 us
	initial begin
		#500_000;
		err_count++;
		print_verdict();
	end

	initial begin
		convDone = 0;
		convResult = 16'h0000;
		highLimit = 16'h1000;
		lowLimit = 16'hf000;
		void'($urandom(12));
		repeat (20) @(posedge mclk);
		sys_rst <= 1'b0;
		linkRst <= 1'b0;
		repeat (5) @(posedge mclk);
		// Reset values
		host.rd(2'h1, rv);
		chk("cfg", rv, 16'h8583);
		host.rd(2'h0, rv);
		chk("convData", rv, 16'h0000);
		chk("gain", 16'(gainRangeSel_q), 16'h0002);
		chk("rate", 16'(sampleRateSel_q), 16'h0004);
		chk("mode", 16'(contMode_q), 16'h0000);
		pin();
		done("reset");
		// Every code of the select, gain, rate and mode fields
		for (int i = 0; i < 8; i++) begin
			w = {1'b0, i[2:0], i[2:0], i[0], i[2:0], 5'($urandom)};
			host.req(3'h1, 2'h1, w);
			repeat (8) @(posedge mclk);
			chk("posSel", 16'(posSel_q), 16'(i == 0 ? 0 : i < 4 ? i - 1 : i - 4));
			chk("negSel", 16'(negSel_q), 16'(i == 0 ? NEG_IN1 : i < 4 ? NEG_IN3 : NEG_GND));
			chk("gain", 16'(gainRangeSel_q), 16'(i > 5 ? 5 : i));
			chk("rate", 16'(sampleRateSel_q), 16'(i));
			chk("mode", 16'(contMode_q), 16'(!i[0]));
			host.rd(2'h1, rv);
			chk("cfgBits", 16'(rv[14:0]), 16'(w[14:0]));
			if (!i[0])
				chk("status", 16'(rv[15]), 16'h0000);
		end
		// Writes to other pointers leave the config alone
		host.req(3'h1, 2'h2, 16'h0123);
		host.rd(2'h1, rv);
		chk("cfgKeep", 16'(rv[14:0]), 16'(w[14:0]));
		conv(16'h0000, 1'b0);
		done("decode");
		// Single shot in ready mode, active high
		@(posedge mclk);
		highLimit <= 16'h8000;
		lowLimit  <= 16'h0000;
		starts = 0;
		host.req(3'h1, 2'h1, 16'h8588);
		repeat (10) @(posedge mclk);
		chk("starts", 16'(starts), 16'h0001);
		host.rd(2'h1, rv);
		chk("status", 16'(rv[15]), 16'h0000);
		chk("ready", 16'(alertOut_q), 16'h0000);
		host.req(3'h1, 2'h1, 16'h8588);
		repeat (10) @(posedge mclk);
		chk("starts", 16'(starts), 16'h0001);
		conv(16'h1234, 1'b0);
		host.rd(2'h1, rv);
		chk("status", 16'(rv[15]), 16'h0001);
		chk("ready", 16'(alertOut_q), 16'h0001);
		host.rd(2'h0, rv);
		chk("convData", rv, 16'h1234);
		host.req(3'h1, 2'h1, 16'h0588);
		repeat (10) @(posedge mclk);
		chk("starts", 16'(starts), 16'h0001);
		// Continuous ready mode: one fixed-length pulse per result
		host.req(3'h1, 2'h1, 16'h0488);
		repeat (8) @(posedge mclk);
		chk("contMode", 16'(contMode_q), 16'h0001);
		chk("rdyIdle", 16'(alertOut_q), 16'h0000);
		@(posedge mclk);
		convResult <= 16'h0100;
		convDone   <= 1'b1;
		@(posedge mclk);
		convDone   <= 1'b0;
		// Count the cycles the active-high ready level stands
		repeat (12) begin
			@(posedge mclk);
			if (alertOut_q === 1'b1)
				pulseLen++;
		end
		chk("rdyPulse", 16'(pulseLen), 16'h0004);
		host.rd(2'h0, rv);
		chk("convData", rv, 16'h0100);
		done("start");
		// Comparator: traditional/two, window/four, latched/one
		@(posedge mclk);
		highLimit <= 16'h1000;
		lowLimit  <= 16'hf000;
		foreach (seq[j]) begin
			if (j > 2)
				break;
			setcfg(16'h0583);
			setcfg(j == 0 ? 16'h0589 : j == 1 ? 16'h0592 : 16'h0584);
			foreach (seq[k])
				conv(val(seq[k]), 1'b1);
			repeat (10) @(posedge mclk);
			chk("pend", 16'(alertPend_q), 16'(act));
			host.req(3'h2, 2'h0, 16'h0000);
			// Only a latched alert is cleared by the host
			if (lat != 0)
				act = 0;
			repeat (10) @(posedge mclk);
			pin();
			conv(val(0), 1'b1);
			host.req(3'h4, 2'h0, 16'h0000);
			if (lat != 0)
				act = 0;
			repeat (10) @(posedge mclk);
			pin();
		end
		done("comparator");
		chk("handshake", 16'(host.errs), 16'h0000);
		print_verdict();
	end
endmodule // adc_config_comparator_control_tb_top
`default_nettype wire
